// *** verilog/nco_regs_defs.vh ***
// Constants for the oscillator configuration and sync register bank.
// Included by the design files of this block; holds definitions only.
`ifndef NCO_REGS_DEFS_VH
`define NCO_REGS_DEFS_VH

// Printed register offsets; some are not multiples of four, so each is an index (byte address = 4 * index)
`define IDX_ACC_RESET      12'h303
`define IDX_SW_SYNC        12'h304
`define IDX_SELF_SYNC      12'h305
`define IDX_SYNC_SRC       12'h306
`define IDX_MODE_CTRL      12'h307
`define IDX_AMP_CH0        12'h318
`define IDX_AMP_CH1        12'h31a
`define IDX_AMP_CH2        12'h31c
`define IDX_AMP_CH3        12'h31e
`define IDX_FREQ0          12'h320
`define IDX_FREQ1          12'h328
// Upper word of a 64-bit frequency value sits at index + 1
`define IDX_HI_STEP        12'h001
`define IDX_STATUS         12'h308

// Reset values
`define RST_ACC_RESET      4'hf
`define RST_BYTE           8'h00
`define RST_AMP            16'h0000
`define RST_OSCILLATOR_FREQUENCY_WORD           64'h0000000000000000

// Field positions of the mode control register
`define MODE_DATAPATH      0
`define MODE_SC_EN         1
`define MODE_CONT          2
`define MODE_FAST_RECONFIG 3

// Sync source codes
`define SRC_REF_LEVEL      2'h2

// Self sync period in sample clocks
`define SELF_SYNC_PERIOD   9'h100
`define SELF_SYNC_CNT_W    8
`define SELF_SYNC_LAST     8'hff

`endif

// *** verilog/shadow_reg.v ***
// Pending/active register pair: software writes the pending copy,
// a sync event moves it to the active copy in one cycle.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module shadow_reg #(
  parameter        W   = 16,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         wr_lo,
  input  wire         wr_hi,
  input  wire [31:0]  wdata,
  input  wire         apply,
  output reg  [W-1:0] pend_ff,
  output reg  [W-1:0] act_ff
);
  reg [W-1:0] nxt_pend;

  // Merge word writes into the pending copy; upper word only exists when W > 32
  always @* begin
    nxt_pend = pend_ff;
    if (wr_lo) begin
      nxt_pend[(W>32 ? 31 : W-1):0] = wdata[(W>32 ? 31 : W-1):0];
    end
    if (wr_hi && W > 32) begin
      nxt_pend[W-1:(W>32 ? 32 : 0)] = wdata[(W>32 ? W-33 : W-1):0];
    end
  end

  // Whole pending value moves at once; a sync landing between the two word writes still applies a half-written word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= RST;
      act_ff  <= RST;
    end else begin
      pend_ff <= nxt_pend;
      if (apply) begin
        act_ff <= pend_ff;
      end
    end
  end
endmodule // shadow_reg
`default_nettype wire

// *** verilog/self_sync_timer.v ***
// Free-running sample clock counter that fires a sync pulse every period
// while enabled. Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`include "nco_regs_defs.vh"
`default_nettype none
module self_sync_timer (
  input  wire pclk,
  input  wire presetn,
  input  wire enable,
  output reg  tick_ff
);
  reg [`SELF_SYNC_CNT_W-1:0] cnt_ff;

  // Restart the count on each enable so the first event lands a full period later;
  // the enable may toggle at any time without upsetting the running datapath
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= {`SELF_SYNC_CNT_W{1'b0}};
      tick_ff <= 1'b0;
    end else if (!enable) begin
      cnt_ff  <= {`SELF_SYNC_CNT_W{1'b0}};
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= cnt_ff + 1'b1;
      tick_ff <= (cnt_ff == `SELF_SYNC_LAST);
    end
  end
endmodule // self_sync_timer
`default_nettype wire

// *** verilog/nco_config_sync_regs.v ***
// Oscillator frequency, DDS amplitude and sync control registers, APB slave.
// Functional notes
// - Self sync fires every 256 sample clocks
// - Self sync enable may change anytime
// - All oscillators take new values together
// - Self coherence seeds all from channel 0 (code: only with self sync on and continuous phase mode off)
// - Four signed 16-bit amplitudes, DDS only
// - Writes stay pending until sync event
// - 64-bit frequency word per oscillator
// - Frequency word signed or unsigned alike
// - Fast reconfiguration masks frequency words
// - Source 2: sync each rising ref edge while trigger
// - Trigger rising write fires; reads last written
// - Reset mask bit resets its accumulator
// Assumes pclk is the sample clock, APB master on the same clock,
// ref_clk is an asynchronous pin and is synchronised here.
`timescale 1ns/1ns
`include "nco_regs_defs.vh"
`default_nettype none
module nco_config_sync_regs (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [15:0]  paddr,
  input  wire [31:0]  pwdata,
  input  wire [3:0]   pstrb,
  output reg  [31:0]  prdata,
  output reg          pready,
  output reg          pslverr,
  input  wire         ref_clk,
  output reg          sync_event,
  output reg  [3:0]   acc_reset,
  output reg          seed_from_ch0,
  output reg          oscillator_frequency_word_valid,
  output reg          dds_amp_valid,
  output reg  [63:0]  oscillator_frequency_word_word0,
  output reg  [63:0]  oscillator_frequency_word_word1,
  output reg  [15:0]  dds_amp0,
  output reg  [15:0]  dds_amp1,
  output reg  [15:0]  dds_amp2,
  output reg  [15:0]  dds_amp3,
  output reg          datapath_enable
);
  // Control registers
  reg  [3:0]  accumulator_reset_mask_ff;
  reg  [7:0]  sw_sync_ff;
  reg  [7:0]  self_sync_control_ff;
  reg  [1:0]  sync_event_source_ff;
  reg  [3:0]  mode_ff;
  reg         ref_s1_ff;
  reg         ref_s2_ff;
  reg         ref_s3_ff;
  reg         sw_pulse_ff;
  reg         sync_count_ff;
  reg  [31:0] nxt_prdata;
  reg         nxt_slverr;

  wire        access      = psel && penable;
  wire        wr_access   = access && pwrite && pready;
  wire [13:0] idx         = paddr[15:2];
  wire        addr_ok     = (paddr[1:0] == 2'b00);
  wire        self_sync_enable      = self_sync_control_ff[0];
  wire        self_coherence_enable = mode_ff[`MODE_SC_EN];
  wire        continuous_phase_mode = mode_ff[`MODE_CONT];
  wire        fast_reconfig_enable  = mode_ff[`MODE_FAST_RECONFIG];
  wire        ss_tick;
  wire        ref_rise    = ref_s2_ff && !ref_s3_ff;
  wire        sync_now;

  // Write strobes into the pending copies, one per word
  wire wr_a0 = wr_access && addr_ok && idx == {2'b00, `IDX_AMP_CH0};
  wire wr_a1 = wr_access && addr_ok && idx == {2'b00, `IDX_AMP_CH1};
  wire wr_a2 = wr_access && addr_ok && idx == {2'b00, `IDX_AMP_CH2};
  wire wr_a3 = wr_access && addr_ok && idx == {2'b00, `IDX_AMP_CH3};
  wire wr_f0l = wr_access && addr_ok && idx == {2'b00, `IDX_FREQ0};
  wire wr_f0h = wr_access && addr_ok && idx == {2'b00, `IDX_FREQ0 + `IDX_HI_STEP};
  wire wr_f1l = wr_access && addr_ok && idx == {2'b00, `IDX_FREQ1};
  wire wr_f1h = wr_access && addr_ok && idx == {2'b00, `IDX_FREQ1 + `IDX_HI_STEP};

  wire [15:0] a0p, a1p, a2p, a3p, a0a, a1a, a2a, a3a;
  wire [63:0] f0p, f1p, f0a, f1a;

  // Sync sources: self-sync timer, software trigger edge, or rising reference edges while trigger high
  assign sync_now = fast_reconfig_enable ? 1'b0 :
                    (ss_tick ||
                     (sync_event_source_ff == `SRC_REF_LEVEL ? (ref_rise && sw_sync_ff[0])
                                                             : sw_pulse_ff));

  self_sync_timer u_ss (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (self_sync_enable),
    .tick_ff (ss_tick)
  );

  // One shared apply strobe so every oscillator switches in the same cycle
  shadow_reg #(
    .W   (16),
    .RST (`RST_AMP)
  ) u_a0 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_lo   (wr_a0),
    .wr_hi   (1'b0),
    .wdata   (pwdata),
    .apply   (sync_now),
    .pend_ff (a0p),
    .act_ff  (a0a)
  );

  shadow_reg #(
    .W   (16),
    .RST (`RST_AMP)
  ) u_a1 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_lo   (wr_a1),
    .wr_hi   (1'b0),
    .wdata   (pwdata),
    .apply   (sync_now),
    .pend_ff (a1p),
    .act_ff  (a1a)
  );

  shadow_reg #(
    .W   (16),
    .RST (`RST_AMP)
  ) u_a2 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_lo   (wr_a2),
    .wr_hi   (1'b0),
    .wdata   (pwdata),
    .apply   (sync_now),
    .pend_ff (a2p),
    .act_ff  (a2a)
  );

  shadow_reg #(
    .W   (16),
    .RST (`RST_AMP)
  ) u_a3 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_lo   (wr_a3),
    .wr_hi   (1'b0),
    .wdata   (pwdata),
    .apply   (sync_now),
    .pend_ff (a3p),
    .act_ff  (a3a)
  );

  shadow_reg #(
    .W   (64),
    .RST (`RST_OSCILLATOR_FREQUENCY_WORD)
  ) u_f0 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_lo   (wr_f0l),
    .wr_hi   (wr_f0h),
    .wdata   (pwdata),
    .apply   (sync_now),
    .pend_ff (f0p),
    .act_ff  (f0a)
  );

  shadow_reg #(
    .W   (64),
    .RST (`RST_OSCILLATOR_FREQUENCY_WORD)
  ) u_f1 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_lo   (wr_f1l),
    .wr_hi   (wr_f1h),
    .wdata   (pwdata),
    .apply   (sync_now),
    .pend_ff (f1p),
    .act_ff  (f1a)
  );

  // Reference pin synchroniser; the second and third stages feed edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
      ref_s3_ff <= 1'b0;
    end else begin
      ref_s1_ff <= ref_clk;
      ref_s2_ff <= ref_s1_ff;
      ref_s3_ff <= ref_s2_ff;
    end
  end

  // Control register writes; trigger pulse on a 0-to-1 write only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulator_reset_mask_ff <= `RST_ACC_RESET;
      sw_sync_ff                <= `RST_BYTE;
      self_sync_control_ff      <= `RST_BYTE;
      sync_event_source_ff      <= 2'b00;
      mode_ff                   <= 4'h0;
      sw_pulse_ff               <= 1'b0;
    end else begin
      sw_pulse_ff <= 1'b0;
      if (wr_access && addr_ok) begin
        case (idx)
          {2'b00, `IDX_ACC_RESET}: accumulator_reset_mask_ff <= pwdata[3:0];
          {2'b00, `IDX_SW_SYNC}: begin
            sw_sync_ff  <= pwdata[7:0];
            sw_pulse_ff <= pwdata[0] && !sw_sync_ff[0];
          end
          {2'b00, `IDX_SELF_SYNC}: self_sync_control_ff <= pwdata[7:0];
          {2'b00, `IDX_SYNC_SRC}: sync_event_source_ff <= pwdata[1:0];
          {2'b00, `IDX_MODE_CTRL}: mode_ff <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // Read mux; reserved bits of byte registers read back as written
  always @* begin
    nxt_prdata = 32'h00000000;
    nxt_slverr = 1'b0;
    if (!addr_ok) begin
      nxt_slverr = 1'b1;
    end else begin
      case (idx)
        {2'b00, `IDX_ACC_RESET}: nxt_prdata = {28'h0000000, accumulator_reset_mask_ff};
        {2'b00, `IDX_SW_SYNC}:   nxt_prdata = {24'h000000, sw_sync_ff};
        {2'b00, `IDX_SELF_SYNC}: nxt_prdata = {24'h000000, self_sync_control_ff};
        {2'b00, `IDX_SYNC_SRC}:  nxt_prdata = {30'h0, sync_event_source_ff};
        {2'b00, `IDX_MODE_CTRL}: nxt_prdata = {28'h0000000, mode_ff};
        {2'b00, `IDX_STATUS}:    nxt_prdata = {31'h0, sync_count_ff};
        {2'b00, `IDX_AMP_CH0}:   nxt_prdata = {16'h0000, a0p};
        {2'b00, `IDX_AMP_CH1}:   nxt_prdata = {16'h0000, a1p};
        {2'b00, `IDX_AMP_CH2}:   nxt_prdata = {16'h0000, a2p};
        {2'b00, `IDX_AMP_CH3}:   nxt_prdata = {16'h0000, a3p};
        {2'b00, `IDX_FREQ0}:     nxt_prdata = f0p[31:0];
        {2'b00, `IDX_FREQ0 + `IDX_HI_STEP}: nxt_prdata = f0p[63:32];
        {2'b00, `IDX_FREQ1}:     nxt_prdata = f1p[31:0];
        {2'b00, `IDX_FREQ1 + `IDX_HI_STEP}: nxt_prdata = f1p[63:32];
        default:                 nxt_slverr = 1'b1;
      endcase
    end
  end

  // Two-cycle APB answer: pready rises in the first access cycle, read data registered with it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? nxt_prdata : 32'h00000000;
      pslverr <= psel && !penable && nxt_slverr;
    end
  end

  // Outputs toward the NCO datapath, all registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_event      <= 1'b0;
      acc_reset       <= 4'h0;
      seed_from_ch0   <= 1'b0;
      oscillator_frequency_word_valid      <= 1'b0;
      dds_amp_valid   <= 1'b0;
      oscillator_frequency_word_word0      <= `RST_OSCILLATOR_FREQUENCY_WORD;
      oscillator_frequency_word_word1      <= `RST_OSCILLATOR_FREQUENCY_WORD;
      dds_amp0        <= `RST_AMP;
      dds_amp1        <= `RST_AMP;
      dds_amp2        <= `RST_AMP;
      dds_amp3        <= `RST_AMP;
      datapath_enable <= 1'b0;
      sync_count_ff   <= 1'b0;
    end else begin
      sync_event      <= sync_now;
      // Mask is applied even under self sync; keeping it zero is software's job
      acc_reset       <= sync_now ? accumulator_reset_mask_ff : 4'h0;
      seed_from_ch0   <= self_sync_enable && self_coherence_enable && !continuous_phase_mode;
      oscillator_frequency_word_valid      <= !fast_reconfig_enable;
      dds_amp_valid   <= !fast_reconfig_enable;
      // Words pass bit-exact so signed and unsigned readings both hold
      oscillator_frequency_word_word0      <= f0a;
      oscillator_frequency_word_word1      <= f1a;
      dds_amp0        <= a0a;
      dds_amp1        <= a1a;
      dds_amp2        <= a2a;
      dds_amp3        <= a3a;
      datapath_enable <= mode_ff[`MODE_DATAPATH];
      if (sync_now) begin
        sync_count_ff <= ~sync_count_ff;
      end
    end
  end
endmodule // nco_config_sync_regs
`default_nettype wire

// *** dv/nco_config_sync_regs_sva.sv ***
// Assertion checker for the oscillator config and sync register bank.
// Sees only the top-level ports; attached by the bind after the module.
`timescale 1ns/1ns
`include "nco_regs_defs.vh"
`default_nettype none
module nco_config_sync_regs_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sync_event,
  input wire logic [3:0]  acc_reset,
  input wire logic        oscillator_frequency_word_valid,
  input wire logic [63:0] oscillator_frequency_word_word0,
  input wire logic [63:0] oscillator_frequency_word_word1,
  input wire logic [15:0] dds_amp0,
  input wire logic [15:0] dds_amp3
);
  localparam logic [15:0] A_SS  = {2'b00, `IDX_SELF_SYNC, 2'b00};
  localparam logic [15:0] A_AR  = {2'b00, `IDX_ACC_RESET, 2'b00};
  localparam logic [15:0] A_SW  = {2'b00, `IDX_SW_SYNC, 2'b00};
  localparam logic [15:0] A_SRC = {2'b00, `IDX_SYNC_SRC, 2'b00};
  logic       wr;
  logic       ss_ff;
  logic       sw_ff;
  logic [3:0] mask_ff;
  logic [1:0] src_ff;
  logic [8:0] gap_ff;
  logic [8:0] run_ff;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed write access
  assign wr = psel && penable && pready && pwrite;
  // Mirror of the programmed mode; counters saturate so they never wrap into a false match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_ff <= 1'b0;
      sw_ff <= 1'b0;
      mask_ff <= `RST_ACC_RESET;
      src_ff <= 2'h0;
      gap_ff <= 9'h0;
      run_ff <= 9'h0;
    end else begin
      if (wr && paddr == A_SS) ss_ff <= pwdata[0];
      if (wr && paddr == A_SW) sw_ff <= pwdata[0];
      if (wr && paddr == A_AR) mask_ff <= pwdata[3:0];
      if (wr && paddr == A_SRC) src_ff <= pwdata[1:0];
      gap_ff <= sync_event ? 9'h0 : gap_ff + {8'h0, gap_ff != 9'h1ff};
      run_ff <= (ss_ff && oscillator_frequency_word_valid) ? run_ff + {8'h0, run_ff != 9'h1ff} : 9'h0;
    end
  end
  sequence trig_wr;
    wr && paddr == A_SW && pwdata[0] && !sw_ff && src_ff != `SRC_REF_LEVEL && oscillator_frequency_word_valid;
  endsequence
  AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_OSCILLATOR_FREQUENCY_WORD_HELD: assert property ($changed(oscillator_frequency_word_word0) |-> $past(sync_event))
    else $error("oscillator_frequency_word_word0 changed without sync");
  AST_AMP_HELD: assert property ($changed(dds_amp0) |-> $past(sync_event))
    else $error("dds_amp0 changed without sync");
  AST_CHANNELS_TOGETHER: assert property ($changed(oscillator_frequency_word_word1) || $changed(dds_amp3)
    |-> $past(sync_event))
    else $error("channel changed outside sync");
  AST_MASK_AT_SYNC: assert property (acc_reset == (sync_event ? mask_ff : 4'h0))
    else $error("acc_reset differs from mask");
  AST_SS_PERIOD: assert property (sync_event && run_ff > 9'd300 |-> gap_ff == 9'd255)
    else $error("self sync period wrong");
  AST_SS_BOUND: assert property (run_ff > 9'd300 |-> gap_ff < 9'd256)
    else $error("self sync missing");
  AST_TRIGGER_FIRES: assert property (trig_wr |-> ##[1:2] sync_event)
    else $error("trigger write gave no sync");
endmodule // nco_config_sync_regs_sva
bind nco_config_sync_regs nco_config_sync_regs_sva nco_config_sync_regs_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .sync_event(sync_event),
  .acc_reset(acc_reset), .oscillator_frequency_word_valid(oscillator_frequency_word_valid), .oscillator_frequency_word_word0(oscillator_frequency_word_word0),
  .oscillator_frequency_word_word1(oscillator_frequency_word_word1), .dds_amp0(dds_amp0), .dds_amp3(dds_amp3));
`default_nettype wire

// *** dv/nco_config_sync_regs_test.sv ***
// Self-checking bench for the oscillator config and sync register bank.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ns
`include "nco_regs_defs.vh"
`default_nettype none
module nco_config_sync_regs_test;
  logic        pclk, presetn, psel, penable, pwrite, ref_clk, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, sync_event, seed, fvalid, avalid, dpath_on;
  wire  [3:0]  acc_reset;
  wire  [63:0] fw0, fw1;
  wire  [15:0] amp0, amp1, amp2, amp3;
  logic [11:0] idx_tab [8];
  logic [31:0] val_tab [8];
  int          fail_count, n_checks, cyc, n_sync, n;
  nco_config_sync_regs nco_config_sync_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_clk(ref_clk), .sync_event(sync_event), .acc_reset(acc_reset), .seed_from_ch0(seed),
    .oscillator_frequency_word_valid(fvalid), .dds_amp_valid(avalid), .oscillator_frequency_word_word0(fw0), .oscillator_frequency_word_word1(fw1), .dds_amp0(amp0),
    .dds_amp1(amp1), .dds_amp2(amp2), .dds_amp3(amp3), .datapath_enable(dpath_on));
  // 100 MHz sample clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Cycle count for the hang limit, and a tally of sync pulses
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (sync_event === 1'b1) n_sync <= n_sync + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high, only the cycle limit ends the wait
  task automatic apb(logic w, logic [11:0] idx, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(string nm, logic [11:0] idx, logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(nm, {31'h0, err, rd}, {32'h0, exp});
  endtask
  task automatic wait_sync(int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sync_event !== 1'b1 && n < lim);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, ref_clk} = 5'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    fail_count = 0;
    n_checks = 0;
    cyc = 0;
    n_sync = 0;
    idx_tab = '{`IDX_AMP_CH0, `IDX_AMP_CH1, `IDX_AMP_CH2, `IDX_AMP_CH3, `IDX_FREQ0,
                `IDX_FREQ0 + `IDX_HI_STEP, `IDX_FREQ1, `IDX_FREQ1 + `IDX_HI_STEP};
    val_tab = '{32'h8000, 32'h7fff, 32'h0001, 32'hffff, 32'hffffffff, 32'hffffffff, 32'h89abcdef, 32'h01234567};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then an unmapped place
    rdchk("self_sync", `IDX_SELF_SYNC, 32'h0);
    rdchk("acc_mask", `IDX_ACC_RESET, 32'hf);
    rdchk("amp0", `IDX_AMP_CH0, 32'h0);
    rdchk("freq0_hi", `IDX_FREQ0 + `IDX_HI_STEP, 32'h0);
    apb(1'b0, 12'h310, 32'h0);
    check("unmapped_err", {63'h0, err}, 64'h1);
    // Writes stay pending until a triggered sync, then land together; datapath still off here
    apb(1'b1, `IDX_ACC_RESET, 32'h0);
    for (int i = 0; i < 8; i++) apb(1'b1, idx_tab[i], val_tab[i]);
    for (int i = 0; i < 8; i++) rdchk("pending", idx_tab[i], val_tab[i]);
    check("fw0_held", fw0, 64'h0);
    check("amp3_held", {48'h0, amp3}, 64'h0);
    apb(1'b1, `IDX_SW_SYNC, 32'h1);
    wait_sync(10);
    check("trigger", {63'h0, sync_event}, 64'h1);
    repeat (2) @(posedge pclk);
    check("fw0", fw0, 64'hffffffffffffffff);
    check("fw1", fw1, 64'h0123456789abcdef);
    check("amps", {amp0, amp1, amp2, amp3}, 64'h80007fff0001ffff);
    // Exactly one sync so far, so the toggle bit reads one
    rdchk("sync_status", `IDX_STATUS, 32'h1);
    n = n_sync;
    apb(1'b1, `IDX_SW_SYNC, 32'h1);
    repeat (4) @(posedge pclk);
    check("no_refire", n_sync, n);
    rdchk("sw_sync", `IDX_SW_SYNC, 32'h1);
    // Self sync period with the datapath running; reload by clear, write, set
    apb(1'b1, `IDX_SW_SYNC, 32'h0);
    apb(1'b1, `IDX_MODE_CTRL, 32'h1);
    apb(1'b1, `IDX_SELF_SYNC, 32'h1);
    check("datapath_enable", {63'h0, dpath_on}, 64'h1);
    wait_sync(400);
    wait_sync(400);
    check("ss_period", n, 256);
    apb(1'b1, `IDX_SELF_SYNC, 32'h0);
    apb(1'b1, `IDX_FREQ0, 32'h5);
    apb(1'b1, `IDX_FREQ0 + `IDX_HI_STEP, 32'h0);
    check("fw0_pending", fw0, 64'hffffffffffffffff);
    apb(1'b1, `IDX_SELF_SYNC, 32'h1);
    wait_sync(400);
    repeat (2) @(posedge pclk);
    check("fw0_reload", fw0, 64'h5);
    // Coherence seeding and fast reconfiguration
    apb(1'b1, `IDX_MODE_CTRL, 32'h3);
    repeat (3) @(posedge pclk);
    check("seed_on", {63'h0, seed}, 64'h1);
    apb(1'b1, `IDX_MODE_CTRL, 32'h7);
    repeat (3) @(posedge pclk);
    check("seed_cont", {63'h0, seed}, 64'h0);
    apb(1'b1, `IDX_MODE_CTRL, 32'hb);
    n = n_sync;
    rdchk("mode", `IDX_MODE_CTRL, 32'hb);
    repeat (300) @(posedge pclk);
    check("fast_valid", {62'h0, fvalid, avalid}, 64'h0);
    check("fast_nosync", n_sync, n);
    apb(1'b1, `IDX_MODE_CTRL, 32'h1);
    apb(1'b1, `IDX_SELF_SYNC, 32'h0);
    // Reference-edge syncs while the trigger bit is held
    apb(1'b1, `IDX_SYNC_SRC, 32'h2);
    rdchk("sync_src", `IDX_SYNC_SRC, 32'h2);
    apb(1'b1, `IDX_SW_SYNC, 32'h1);
    repeat (8) @(posedge pclk);
    n = n_sync;
    repeat (4) begin
      repeat (20) @(posedge pclk);
      ref_clk <= 1'b1;
      repeat (20) @(posedge pclk);
      ref_clk <= 1'b0;
    end
    check("ref_syncs", n_sync - n, 4);
    // Mask bits show on the accumulator resets only in the sync cycle
    apb(1'b1, `IDX_ACC_RESET, 32'h5);
    ref_clk <= 1'b1;
    wait_sync(10);
    check("acc_reset", {60'h0, acc_reset}, 64'h5);
    summarize();
  end
endmodule // nco_config_sync_regs_test
`default_nettype wire
